// File: rtr_pkg.sv
// shared constants for the radio tuning register bank and its host
package rtr_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS    = 10;                  // 100 MHz system clock
    localparam int T_POR_WAIT_NS    = 10_000_000;          // 10 ms quiet time after power-on
    localparam int T_RST_PULSE_NS   = 100_000;             // 100 us manual reset pulse
    localparam int T_MAN_WAIT_NS    = 5_000_000;           // 5 ms quiet time after manual reset
    localparam int POR_WAIT_CYC     = (T_POR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_PULSE_CYC    = (T_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAN_WAIT_CYC     = (T_MAN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEV_START_CYC    = 64;                  // device internal start-up length
    localparam int SPI_HALF_CYC     = 4;                   // system cycles per serial half bit
    localparam int DIVIDED_CLOCK_OUTPUT_HALF_CYC  = 2;                   // system cycles per clock-out half period
    localparam int CNT_W            = 24;                  // width of long wait counters
    // serial frame: write flag, 7-bit address, 8-bit data
    localparam int FRAME_BITS       = 16;
    localparam int WNR_BIT          = 15;
    // device register addresses
    localparam logic [6:0] ADDR_LNA  = 7'h58;
    localparam logic [6:0] ADDR_PA1  = 7'h5a;
    localparam logic [6:0] ADDR_PA2  = 7'h5c;
    localparam logic [6:0] ADDR_DAGC = 7'h6f;
    localparam logic [6:0] ADDR_AFC  = 7'h71;
    // register values with meaning
    localparam logic [7:0] LNA_NORMAL    = 8'h1b;
    localparam logic [7:0] LNA_HIGH      = 8'h2d;
    localparam logic [7:0] PA1_NORMAL    = 8'h55;
    localparam logic [7:0] PA1_BOOST     = 8'h5d;
    localparam logic [7:0] PA2_NORMAL    = 8'h70;
    localparam logic [7:0] PA2_BOOST     = 8'h7c;
    localparam logic [7:0] DAGC_NORMAL   = 8'h00;
    localparam logic [7:0] DAGC_CORR_ON  = 8'h20;
    localparam logic [7:0] DAGC_CORR_OFF = 8'h30;
    localparam logic [7:0] AFC_ZERO      = 8'h00;
    localparam logic [8:0] AFC_STEP_HZ   = 9'h1e8;         // 488 Hz per offset step
    // reset values
    localparam logic [7:0] RST_LNA  = LNA_NORMAL;
    localparam logic [7:0] RST_PA1  = PA1_NORMAL;
    localparam logic [7:0] RST_PA2  = PA2_NORMAL;
    localparam logic [7:0] RST_DAGC = DAGC_CORR_OFF;
    localparam logic [7:0] RST_AFC  = AFC_ZERO;
    // host register map
    localparam logic [3:0] HREG_CTRL    = 4'h0;
    localparam logic [3:0] HREG_ADDR    = 4'h1;
    localparam logic [3:0] HREG_WDATA   = 4'h2;
    localparam logic [3:0] HREG_RDATA   = 4'h3;
    localparam logic [3:0] HREG_STATUS  = 4'h4;
    localparam logic [3:0] HREG_PROFILE = 4'h5;
    // host field positions
    localparam int CTRL_START  = 0;
    localparam int CTRL_WRITE  = 1;
    localparam int CTRL_RESET  = 2;
    localparam int ST_READY    = 0;
    localparam int ST_BUSY     = 1;
    localparam int ST_CLK_SEEN = 2;
    localparam int PROF_BOOST  = 0;
    localparam int PROF_CORR   = 1;
endpackage : rtr_pkg

// File: rtr_link_if.sv
// serial bus, reset pin and clock output between host and radio
`timescale 1ns/1ps
interface rtr_link_if;
    logic sck;        // serial clock, host driven
    logic mosi;       // host to device data
    logic miso;       // device to host data
    logic nss_n;      // frame select, active low
    logic rst_out;    // host drive value for reset pin
    logic rst_oe_n;   // host output enable, active low
    logic rst_level;  // resolved reset pin level
    logic clk_out;    // divided clock output of device
    // undriven pin is pulled low inside the interface
    assign rst_level = ~rst_oe_n & rst_out;
    modport dev  (input sck, mosi, nss_n, rst_level, output miso, clk_out);
    modport host (output sck, mosi, nss_n, rst_out, rst_oe_n, input miso, clk_out);
endinterface : rtr_link_if

// File: rtr_spi_master.sv
// serial frame shifter used by the host, mode 0, msb first
`timescale 1ns/1ps
module rtr_spi_master (
    // clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_reset_n,
    // frame request
    input  wire logic                            i_start,
    input  wire logic [rtr_pkg::FRAME_BITS-1:0]  i_frame,
    output logic                                 o_done,
    output logic [7:0]                           o_rdata,
    // serial pins
    input  wire logic                            i_miso,
    output logic                                 o_sck,
    output logic                                 o_mosi,
    output logic                                 o_nss_n
);
    import rtr_pkg::*;
    logic                  busy;      // frame in progress
    logic [2:0]            div;       // half-bit divider
    logic [4:0]            phase;     // half-bit index
    logic [FRAME_BITS-1:0] shreg;     // outgoing bits
    wire                   tick = busy & (div == 3'(SPI_HALF_CYC - 1));

    // half-bit enable pulse
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) div <= 3'h0;
        else if (!busy || tick) div <= 3'h0;
        else div <= div + 3'h1;
    end

    // shifting: sample on rise, drive on fall
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy <= 1'b0; phase <= 5'h0; shreg <= '0; o_done <= 1'b0; o_rdata <= 8'h00;
            o_sck <= 1'b0; o_mosi <= 1'b0; o_nss_n <= 1'b1;
        end else begin
            o_done <= 1'b0;
            if (i_start && !busy) begin
                busy <= 1'b1; phase <= 5'h0; shreg <= i_frame;
                o_mosi <= i_frame[FRAME_BITS-1]; o_nss_n <= 1'b0;
            end else if (tick) begin
                phase <= phase + 5'h1;
                if (!phase[0]) begin
                    o_sck   <= 1'b1;
                    o_rdata <= {o_rdata[6:0], i_miso};
                end else if (phase == 5'h1f) begin
                    o_sck <= 1'b0; o_nss_n <= 1'b1; busy <= 1'b0; o_done <= 1'b1;
                end else begin
                    o_sck  <= 1'b0;
                    o_mosi <= shreg[FRAME_BITS-2];
                    shreg  <= {shreg[FRAME_BITS-2:0], 1'b0};
                end
            end
        end
    end
endmodule : rtr_spi_master

// File: rtr_device.sv
// radio tuning register bank with reset sequencing and serial slave
`timescale 1ns/1ps
module rtr_device (
    // clock and supply reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // link to host
    rtr_link_if.dev          link,
    // radio core side
    input  wire logic        i_narrow_index_correction_enable,
    output logic             o_ready,
    output logic             o_lna_high_sens,
    output logic             o_max_power_mode,
    output logic             o_fading_margin_on,
    output logic [7:0]       o_fading_margin_select,
    output logic [16:0]      o_freq_offset_hz
);
    import rtr_pkg::*;
    logic [7:0]  regs [5];       // tuning registers by index
    logic [6:0]  start_cnt;      // start-up countdown
    logic        sck_q;          // previous serial clock
    logic [3:0]  bitcnt;         // bits taken in frame
    logic [14:0] shin;           // incoming bits
    logic [7:0]  shout;          // outgoing read byte
    logic        miso;           // data to host
    logic [1:0]  cdiv;           // clock-out divider
    logic        clk_o;          // clock-out level

    // address to register index, 7 when unmapped
    function automatic logic [2:0] reg_index(input logic [6:0] a);
        unique case (a)
            ADDR_LNA:  reg_index = 3'h0;
            ADDR_PA1:  reg_index = 3'h1;
            ADDR_PA2:  reg_index = 3'h2;
            ADDR_DAGC: reg_index = 3'h3;
            ADDR_AFC:  reg_index = 3'h4;
            default:   reg_index = 3'h7;
        endcase
    endfunction : reg_index

    wire       pin_rst  = link.rst_level;                 // manual reset level
    wire       rise     = ~link.nss_n & link.sck & ~sck_q;
    wire       fall     = ~link.nss_n & ~link.sck & sck_q;
    wire [2:0] wr_idx   = reg_index(shin[13:7]);
    wire [2:0] rd_idx   = reg_index(shin[6:0]);
    wire       wr_hit   = rise & (bitcnt == 4'hf) & shin[14] & o_ready & (wr_idx != 3'h7);
    wire [7:0] rd_val   = (o_ready && rd_idx != 3'h7) ? regs[rd_idx] : 8'h00;
    wire [16:0] offs    = 17'(regs[4]) * 17'(AFC_STEP_HZ);

    // start-up: supply reset and pin reset both restart it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) start_cnt <= 7'(DEV_START_CYC - 1);
        else if (pin_rst) start_cnt <= 7'(DEV_START_CYC - 1);
        else if (start_cnt != 7'h0) start_cnt <= start_cnt - 7'h1;
    end

    // ready once start-up ends and the pin is low
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) o_ready <= 1'b0;
        else o_ready <= ~pin_rst & (start_cnt == 7'h0);
    end

    // clock output runs only when ready
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cdiv <= 2'h0; clk_o <= 1'b0;
        end else if (!o_ready) begin
            cdiv <= 2'h0; clk_o <= 1'b0;
        end else if (cdiv == 2'(DIVIDED_CLOCK_OUTPUT_HALF_CYC - 1)) begin
            cdiv <= 2'h0; clk_o <= ~clk_o;
        end else cdiv <= cdiv + 2'h1;
    end

    // register file: defaults on either reset, writes only when ready
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            regs[0] <= RST_LNA; regs[1] <= RST_PA1; regs[2] <= RST_PA2;
            regs[3] <= RST_DAGC; regs[4] <= RST_AFC;
        end else if (pin_rst) begin
            regs[0] <= RST_LNA; regs[1] <= RST_PA1; regs[2] <= RST_PA2;
            regs[3] <= RST_DAGC; regs[4] <= RST_AFC;
        end else if (wr_hit) begin
            regs[wr_idx] <= {shin[6:0], link.mosi};
        end
    end

    // serial receive: bits taken on rising edges
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_q <= 1'b0; bitcnt <= 4'h0; shin <= '0;
        end else begin
            sck_q <= link.sck;
            if (link.nss_n) bitcnt <= 4'h0;
            else if (rise) begin
                bitcnt <= bitcnt + 4'h1;
                shin   <= {shin[13:0], link.mosi};
            end
        end
    end

    // serial transmit: read byte loaded after the address, shifted on falls
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shout <= 8'h00; miso <= 1'b0;
        end else if (fall && bitcnt == 4'h8) begin
            miso <= rd_val[7]; shout <= {rd_val[6:0], 1'b0};
        end else if (fall) begin
            miso <= shout[7]; shout <= {shout[6:0], 1'b0};
        end
    end

    // radio settings decoded from the registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_lna_high_sens <= 1'b0; o_max_power_mode <= 1'b0;
            o_fading_margin_on <= 1'b0; o_fading_margin_select <= RST_DAGC; o_freq_offset_hz <= '0;
        end else begin
            o_lna_high_sens        <= (regs[0] == LNA_HIGH);
            o_max_power_mode       <= (regs[1] == PA1_BOOST) & (regs[2] == PA2_BOOST);
            o_fading_margin_on     <= (regs[3] != DAGC_NORMAL);
            o_fading_margin_select <= regs[3];
            o_freq_offset_hz       <= i_narrow_index_correction_enable ? offs : 17'h0;
        end
    end

    assign link.miso    = miso;
    assign link.clk_out = clk_o;
endmodule : rtr_device

// File: rtr_host.sv
// host controller: reset sequencing, waits and register access to the radio
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module rtr_host #(
    parameter int POR_WAIT    = rtr_pkg::POR_WAIT_CYC,   // cycles after clock-out seen
    parameter int RST_PULSE   = rtr_pkg::RST_PULSE_CYC,  // cycles of pin drive
    parameter int MAN_WAIT    = rtr_pkg::MAN_WAIT_CYC    // cycles after pin release
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // software register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [7:0]       o_rdata,
    // link to radio
    rtr_link_if.host         link
);
    import rtr_pkg::*;

    // boot, quiet wait, idle, frame, reset pulse
    typedef enum logic [2:0] {H_BOOT, H_WAIT, H_READY, H_XFER, H_PULSE} rtr_hstate_t;

    // sequencer and wait counting
    rtr_hstate_t             state;      // sequencer state
    logic [CNT_W-1:0]        cnt;        // wait countdown
    logic                    rst_out;    // reset pin value
    logic                    rst_oe_n;   // reset pin enable, low drives
    // software-visible registers and the profile write count
    logic [6:0]              dev_addr;   // target register address
    logic [7:0]              dev_wdata;  // data for a write
    logic [7:0]              dev_rdata;  // last read result
    logic [1:0]              prof;       // boost and correction choice
    logic [1:0]              seq_left;   // profile writes still to send
    // queued requests
    logic                    pend;       // user transfer requested
    logic                    pend_wr;    // requested transfer is a write
    logic                    rst_req;    // manual reset requested
    // clock-out watch
    logic                    clk_q;      // previous clock-out level
    logic                    clk_seen;   // clock-out activity observed
    // serial shifter handshake
    logic                    in_seq;     // running transfer is a profile write
    logic                    spi_start;  // frame launch pulse
    logic [FRAME_BITS-1:0]   spi_frame;  // frame to send
    logic                    spi_done;   // frame finished
    logic [7:0]              spi_rdata;  // byte shifted in

    // software decode
    wire        wr_ctrl  = i_wr & (i_addr == HREG_CTRL);
    wire        wr_addr  = i_wr & (i_addr == HREG_ADDR);
    wire        wr_wdata = i_wr & (i_addr == HREG_WDATA);
    wire        wr_prof  = i_wr & (i_addr == HREG_PROFILE);
    wire        clk_edge = link.clk_out & ~clk_q;
    wire        ready    = (state == H_READY);
    // status: ready, frame busy, clock-out seen
    wire [7:0]  status   = {5'h0, clk_seen, (state == H_XFER), ready};

    // profile write contents
    wire [7:0]  pa1_val  = prof[PROF_BOOST] ? PA1_BOOST : PA1_NORMAL;
    wire [7:0]  pa2_val  = prof[PROF_BOOST] ? PA2_BOOST : PA2_NORMAL;
    wire [7:0]  dagc_val = prof[PROF_CORR] ? DAGC_CORR_ON : DAGC_CORR_OFF;
    wire [14:0] seq_body = (seq_left == 2'h3) ? {ADDR_PA1, pa1_val} :
                           (seq_left == 2'h2) ? {ADDR_PA2, pa2_val} : {ADDR_DAGC, dagc_val};
    wire [14:0] usr_body = {dev_addr, dev_wdata};

    // serial shifter
    rtr_spi_master rtr_spi_master_inst (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_start   (spi_start),
        .i_frame   (spi_frame),
        .o_done    (spi_done),
        .o_rdata   (spi_rdata),
        .i_miso    (link.miso),
        .o_sck     (link.sck),
        .o_mosi    (link.mosi),
        .o_nss_n   (link.nss_n)
    );

    // software-written registers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dev_addr <= 7'h0; dev_wdata <= 8'h00; prof <= 2'h0;
        end else begin
            // only the low seven bits form a device address
            if (wr_addr)  dev_addr  <= i_wdata[6:0];
            if (wr_wdata) dev_wdata <= i_wdata;
            if (wr_prof)  prof      <= i_wdata[1:0];
        end
    end

    // read port, data one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) o_rdata <= 8'h00;
        else if (i_rd) begin
            // unmapped addresses read back as zero
            unique case (i_addr)
                HREG_ADDR:    o_rdata <= {1'b0, dev_addr};
                HREG_WDATA:   o_rdata <= dev_wdata;
                HREG_RDATA:   o_rdata <= dev_rdata;
                HREG_STATUS:  o_rdata <= status;
                HREG_PROFILE: o_rdata <= {6'h0, prof};
                default:      o_rdata <= 8'h00;
            endcase
        end else o_rdata <= 8'h00;
    end

    // clock-out watcher, cleared when a manual reset starts
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clk_q <= 1'b0; clk_seen <= 1'b0;
        end else begin
            clk_q <= link.clk_out;
            // a fresh rise wins over the clear
            if (clk_edge) clk_seen <= 1'b1;
            else if (state == H_PULSE) clk_seen <= 1'b0;
        end
    end

    // main sequencer
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= H_BOOT; cnt <= '0; rst_out <= 1'b0; rst_oe_n <= 1'b1;
            seq_left <= 2'h0; pend <= 1'b0; pend_wr <= 1'b0; rst_req <= 1'b0;
            in_seq <= 1'b0; spi_start <= 1'b0; spi_frame <= '0; dev_rdata <= 8'h00;
        end else begin
            spi_start <= 1'b0;
            unique case (state)
                // pin left floating until the device shows life
                H_BOOT: begin
                    rst_oe_n <= 1'b1;
                    // first clock-out rise starts the power-on wait
                    if (clk_edge) begin
                        state <= H_WAIT;
                        cnt   <= CNT_W'(POR_WAIT - 1);
                    end
                end
                // quiet time before any access
                H_WAIT: begin
                    // zero count opens the link to requests
                    if (cnt == '0) state <= H_READY;
                    else cnt <= cnt - CNT_W'(1);
                end
                // launch: reset first, then profile writes, then user frame
                H_READY: begin
                    // manual reset outranks any queued frame
                    if (rst_req) begin
                        state <= H_PULSE; rst_req <= 1'b0;
                        rst_out <= 1'b1; rst_oe_n <= 1'b0;
                        cnt <= CNT_W'(RST_PULSE - 1);
                    end else if (seq_left != 2'h0) begin
                        state <= H_XFER; in_seq <= 1'b1; spi_start <= 1'b1;
                        // profile frames always carry the write flag
                        spi_frame <= {1'b1, seq_body};
                    end else if (pend) begin
                        state <= H_XFER; in_seq <= 1'b0; spi_start <= 1'b1; pend <= 1'b0;
                        // user frame: write flag chosen by software
                        spi_frame <= {pend_wr, usr_body};
                    end
                end
                // frame in flight
                H_XFER: begin
                    if (spi_done) begin
                        state <= H_READY;
                        // profile frames count down, user frames keep their byte
                        if (in_seq) seq_left <= seq_left - 2'h1;
                        else dev_rdata <= spi_rdata;
                    end
                end
                // pin driven high, then released to the pull-down
                H_PULSE: begin
                    if (cnt == '0) begin
                        // pulse over: float the pin again
                        rst_out <= 1'b0; rst_oe_n <= 1'b1;
                        state <= H_WAIT; cnt <= CNT_W'(MAN_WAIT - 1);
                    end else cnt <= cnt - CNT_W'(1);
                end
            endcase
            // requests from software; a set wins over the launch clear
            if (wr_prof) seq_left <= 2'h3;
            if (wr_ctrl && i_wdata[CTRL_START]) begin
                pend <= 1'b1; pend_wr <= i_wdata[CTRL_WRITE];
            end
            // manual reset waits until the link is idle
            if (wr_ctrl && i_wdata[CTRL_RESET]) rst_req <= 1'b1;
        end
    end

    // reset pin drive toward the radio
    assign link.rst_out  = rst_out;
    assign link.rst_oe_n = rst_oe_n;
endmodule : rtr_host

// File: rtr_link_properties.sv
// link checker for the radio reset pin, clock output and serial frames
`timescale 1ns/1ps
module rtr_link_properties #(
    parameter int POR_WAIT  = 200,
    parameter int RST_PULSE = 20,
    parameter int MAN_WAIT  = 100
) (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // link signals
    input  wire logic nss_n,
    input  wire logic rst_out,
    input  wire logic rst_oe_n,
    input  wire logic rst_level,
    input  wire logic clk_out
);
    logic        seen;    // first clock-out rise seen
    logic        clk_q;   // clock-out one cycle back
    logic [15:0] por_cnt; // cycles since first rise
    logic [15:0] drv_cnt; // cycles of pin drive
    logic [15:0] man_cnt; // cycles since pin release
    // helper counters; por_cnt and man_cnt saturate, drv_cnt wraps
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seen    <= 1'b0;
            clk_q   <= 1'b0;
            por_cnt <= '0;
            drv_cnt <= '0;
            man_cnt <= '1;
        end else begin
            clk_q   <= clk_out;
            seen    <= seen | (clk_out & ~clk_q);
            por_cnt <= (seen && por_cnt != '1) ? por_cnt + 16'h1 : por_cnt;
            drv_cnt <= rst_oe_n ? 16'h0 : drv_cnt + 16'h1;
            man_cnt <= !rst_oe_n ? 16'h0 : (man_cnt != '1 ? man_cnt + 16'h1 : man_cnt);
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    chk_por_pin_float: assert property (!seen |-> rst_oe_n)
        else $error("reset pin driven during start-up");
    chk_por_quiet_time: assert property ($fell(nss_n) |-> por_cnt >= POR_WAIT)
        else $error("frame too soon after start-up");
    chk_pulse_length: assert property ($rose(rst_oe_n) |-> drv_cnt == RST_PULSE)
        else $error("reset pulse length wrong");
    chk_pulse_level: assert property (!rst_oe_n |-> rst_out && rst_level)
        else $error("reset pin not driven high");
    chk_manual_quiet: assert property ($fell(nss_n) |-> man_cnt >= MAN_WAIT)
        else $error("frame too soon after pin reset");
    chk_divided_clock_output_period: assert property ($rose(clk_out) && rst_oe_n ##1 rst_oe_n |-> clk_out ##1 !clk_out)
        else $error("clock output period wrong");
    chk_divided_clock_output_stops: assert property (rst_level [*4] |-> !clk_out)
        else $error("clock output runs in pin reset");
    chk_no_frame_reset: assert property (!rst_oe_n |-> nss_n)
        else $error("frame during pin reset");
endmodule : rtr_link_properties

// File: test_radio_test_regs_and_reset.sv
// self-checking bench for the radio tuning registers and reset sequencing
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_radio_test_regs_and_reset;
    import rtr_pkg::*;
    logic        i_clk     = 1'b0; // system clock
    logic        i_reset_n = 1'b0; // power-on reset
    logic [3:0]  i_addr    = 4'h0;
    logic [7:0]  i_wdata   = 8'h00;
    logic        i_wr      = 1'b0;
    logic        i_rd      = 1'b0;
    logic        corr_en   = 1'b0; // narrow index correction
    logic [7:0]  o_rdata, fsel, v;
    logic        rdy, lna_hi, max_pw, f_on;
    logic [16:0] foff;
    int          err_count = 0;
    int          checked   = 0;
    rtr_link_if rtr_link_if_inst ();
    rtr_host #(.POR_WAIT(200), .RST_PULSE(20), .MAN_WAIT(100)) rtr_host_inst (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .link(rtr_link_if_inst));
    rtr_device rtr_device_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(rtr_link_if_inst),
        .i_narrow_index_correction_enable(corr_en), .o_ready(rdy), .o_lna_high_sens(lna_hi),
        .o_max_power_mode(max_pw), .o_fading_margin_on(f_on), .o_fading_margin_select(fsel),
        .o_freq_offset_hz(foff));
    // checker defaults equal the short host waits above
    rtr_link_properties rtr_link_properties_inst (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .nss_n(rtr_link_if_inst.nss_n),
        .rst_out(rtr_link_if_inst.rst_out), .rst_oe_n(rtr_link_if_inst.rst_oe_n),
        .rst_level(rtr_link_if_inst.rst_level), .clk_out(rtr_link_if_inst.clk_out));
    always #5 i_clk = ~i_clk;
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // one-cycle software write and read
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask : rd
    // three idle status reads in a row, bounded
    task automatic wait_idle;
        int ok;
        ok = 0;
        for (int n = 0; n < 3000 && ok < 3; n++) begin
            rd(HREG_STATUS);
            ok = (v[ST_READY] === 1'b1 && v[ST_BUSY] === 1'b0) ? ok + 1 : 0;
        end
        if (ok < 3) begin
            err_count++;
            test_done();
        end
    endtask : wait_idle
    task automatic dev_wr(input logic [6:0] a, input logic [7:0] d);
        wr(HREG_ADDR, {1'b0, a});
        wr(HREG_WDATA, d);
        wr(HREG_CTRL, 8'h03);
        wait_idle();
    endtask : dev_wr
    task automatic dev_rd(input logic [6:0] a);
        wr(HREG_ADDR, {1'b0, a});
        wr(HREG_CTRL, 8'h01);
        wait_idle();
        rd(HREG_RDATA);
    endtask : dev_rd
    task automatic s_defaults;
        logic [6:0] a [5];
        logic [7:0] e [5];
        a = '{ADDR_LNA, ADDR_PA1, ADDR_PA2, ADDR_DAGC, ADDR_AFC};
        e = '{8'h1b, 8'h55, 8'h70, 8'h30, 8'h00};
        for (int i = 0; i < 5; i++) begin
            dev_rd(a[i]);
            `CHK(v, e[i])
        end
        `CHK(rdy, 1'b1)
        `CHK(lna_hi, 1'b0)
        `CHK(fsel, 8'h30)
    endtask : s_defaults
    task automatic s_lna;
        dev_wr(ADDR_LNA, 8'h2d);
        `CHK(lna_hi, 1'b1)
        dev_rd(ADDR_LNA);
        `CHK(v, 8'h2d)
        rd(4'hf);
        `CHK(v, 8'h00)
    endtask : s_lna
    task automatic s_profile(input logic [7:0] p, input logic [7:0] e1, e2, e3, input logic mp);
        @(posedge i_clk);
        corr_en <= p[PROF_CORR];
        wr(HREG_PROFILE, p);
        wait_idle();
        dev_rd(ADDR_PA1);
        `CHK(v, e1)
        dev_rd(ADDR_PA2);
        `CHK(v, e2)
        dev_rd(ADDR_DAGC);
        `CHK(v, e3)
        `CHK(max_pw, mp)
        `CHK(f_on, 1'b1)
    endtask : s_profile
    task automatic s_offset;
        dev_wr(ADDR_AFC, 8'hff);
        @(posedge i_clk);
        corr_en <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 `CHK(foff, 17'(255) * 17'(488))
        @(posedge i_clk);
        corr_en <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1 `CHK(foff, 17'h0)
    endtask : s_offset
    task automatic s_manual;
        wr(HREG_CTRL, 8'h04);
        rd(HREG_STATUS);
        `CHK(v[ST_READY], 1'b0)
        `CHK(rdy, 1'b0)
        wait_idle();
        `CHK(v[ST_CLK_SEEN], 1'b1)
        s_defaults();
    endtask : s_manual
    initial begin
        repeat (6) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wait_idle();
        s_defaults();
        s_lna();
        s_profile(8'h03, 8'h5d, 8'h7c, 8'h20, 1'b1);
        s_profile(8'h00, 8'h55, 8'h70, 8'h30, 1'b0);
        s_offset();
        s_manual();
        test_done();
    end
endmodule : test_radio_test_regs_and_reset
